// ===== rtl/dao_pkg.sv
// Behaviour
// - Each channel drives its own three-state 10-bit bus, bit 9 MSB, bit 0 LSB.
// - Every sample passes a nine-stage pipeline, one stage per half clock.
// - Output word appears five clock cycles after its sample; capture aligns to it.
// - Format select low gives straight offset binary, zero at 10 0000 0000.
// - Format select high gives two's complement, zero at 00 0000 0000.
// - Stage 1.5-bit decisions merge by digital error correction without missing codes.
// - Output enable low drives both buses; high releases them to high impedance.
// - Samples are taken on rising edges; data is valid by the next rising edge.
// - Power-down with outputs enabled holds the last word produced before it.
package dao_pkg;
  localparam int DATA_W      = 10;
  localparam int CHAN_MSB    = 9;
  localparam int CHAN_LSB    = 0;
  localparam int NUM_STAGES  = 9;
  localparam int DEC_W       = 2;
  localparam int DEC_VEC_W   = NUM_STAGES * DEC_W;
  localparam int PAIR_W      = 2 * DATA_W;
  localparam int LATENCY_CYC = 5;
  // Cycles of the fifo read register and the output latch; the fifo write cycle is not counted.
  localparam int TAIL_CYC    = 2;
  localparam int PIPE_CYC    = LATENCY_CYC - TAIL_CYC;
  localparam int FIFO_DEPTH  = 16;
  localparam int CLK_NS      = 50;
  localparam logic [DATA_W-1:0] CODE_MAX   = 10'h3ff;
  localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;
  localparam logic [DATA_W:0]   SUM_RESET  = 11'h000;
  localparam logic [1:0]        SYNC_HIGH  = 2'h3;
  localparam logic [1:0]        SYNC_LOW   = 2'h0;
endpackage : dao_pkg

// ===== rtl/dao_stream_if.sv
`timescale 1ns/100ps
interface dao_stream_if #(
  parameter int WIDTH = 20
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dao_stream_if

// ===== rtl/dao_fifo.sv
`timescale 1ns/100ps
module dao_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  dao_stream_if.snk      wrSide,
  dao_stream_if.src      rdSide
);
  localparam int PTR_W = $clog2(DEPTH);

  // Elaboration checks: the pointers wrap by their extra bit, so DEPTH must be a power of two.
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
    $error("dao_fifo: DEPTH must be a power of two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("dao_fifo: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0]   wrPtr;
  logic [PTR_W:0]   rdPtr;
  logic [PTR_W:0]   next_wrPtr;
  logic [PTR_W:0]   next_rdPtr;
  logic [WIDTH-1:0] rdData;
  logic [WIDTH-1:0] next_rdData;
  logic             rdValid;
  logic             next_rdValid;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full          = (wrPtr[PTR_W] != rdPtr[PTR_W]) && (wrPtr[PTR_W-1:0] == rdPtr[PTR_W-1:0]);
  assign empty         = (wrPtr == rdPtr);
  assign push          = wrSide.valid && !full;
  assign pop           = rdSide.ready && !empty;
  assign wrSide.ready  = !full;
  assign rdSide.valid  = rdValid;
  assign rdSide.data   = rdData;

  always_comb begin
    next_wrPtr   = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr   = pop ? rdPtr + 1'b1 : rdPtr;
    next_rdData  = pop ? mem[rdPtr[PTR_W-1:0]] : rdData;
    next_rdValid = pop;
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr[PTR_W-1:0]] <= wrSide.data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      rdData  <= '0;
      rdValid <= 1'b0;
    end else begin
      wrPtr   <= next_wrPtr;
      rdPtr   <= next_rdPtr;
      rdData  <= next_rdData;
      rdValid <= next_rdValid;
    end
  end
endmodule : dao_fifo

// ===== rtl/dao_formatter.sv
`timescale 1ns/100ps
module dao_formatter #(
  parameter int LATENCY = dao_pkg::LATENCY_CYC,
  parameter int DEPTH   = dao_pkg::FIFO_DEPTH
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         sampleValid,
  input  wire logic [dao_pkg::DEC_VEC_W-1:0] chanADecision,
  input  wire logic [dao_pkg::DEC_VEC_W-1:0] chanBDecision,
  input  wire logic                         formatTwos,
  input  wire logic                         outEnable_b,
  input  wire logic                         fullPowerDown,
  output logic                              sampleReady,
  output logic [dao_pkg::DATA_W-1:0]        chanAData,
  output logic                              chanADataOe,
  output logic [dao_pkg::DATA_W-1:0]        chanBData,
  output logic                              chanBDataOe
);
  localparam int PIPE = LATENCY - dao_pkg::TAIL_CYC;

  // Elaboration checks: at least one pipeline register must stand ahead of the fifo.
  if (PIPE < 1) begin : g_bad_latency
    $error("dao_formatter: LATENCY must be at least 3");
  end
  if (DEPTH < 2) begin : g_bad_depth
    $error("dao_formatter: DEPTH must be at least 2");
  end

  // Merges the stage decisions. Each 1.5-bit stage reports 0, 1 or 2 for
  // -1, 0, +1 around its midpoint, and the last stage is a 2-bit flash. The
  // overlap absorbs comparator offsets, so any residue error that stays inside
  // one stage's redundancy is corrected by the next stage and no code is lost.
  function automatic logic [dao_pkg::DATA_W-1:0] correct(input logic [dao_pkg::DEC_VEC_W-1:0] dec);
    logic [dao_pkg::DATA_W:0] sum;
    logic [dao_pkg::DEC_W-1:0] d;
    sum = dao_pkg::SUM_RESET;
    for (int i = 0; i < dao_pkg::NUM_STAGES; i++) begin
      d = dec[dao_pkg::DEC_VEC_W-1-i*dao_pkg::DEC_W -: dao_pkg::DEC_W];
      if (i < dao_pkg::NUM_STAGES - 1 && d == 2'h3) begin
        d = 2'h2;
      end
      sum = sum + ((dao_pkg::DATA_W+1)'(d) << (dao_pkg::NUM_STAGES - 1 - i));
    end
    if (sum > {1'b0, dao_pkg::CODE_MAX}) begin
      correct = dao_pkg::CODE_MAX;
    end else begin
      correct = sum[dao_pkg::DATA_W-1:0];
    end
  endfunction : correct

  // Offset binary is the native code; two's complement only inverts the MSB.
  function automatic logic [dao_pkg::DATA_W-1:0] encode(input logic [dao_pkg::DATA_W-1:0] raw,
                                                        input logic twos);
    encode = raw;
    if (twos) begin
      encode[dao_pkg::CHAN_MSB] = ~raw[dao_pkg::CHAN_MSB];
    end
  endfunction : encode

  // Pin synchronisers; the first flop feeds only the second.
  logic [1:0] syncFmt;
  logic [1:0] syncOe;
  logic [1:0] syncPd;
  logic [1:0] next_syncFmt;
  logic [1:0] next_syncOe;
  logic [1:0] next_syncPd;
  logic       fmtTwos;
  logic       oeActive;
  logic       pdActive;

  always_comb begin
    next_syncFmt = {syncFmt[0], formatTwos};
    next_syncOe  = {syncOe[0], outEnable_b};
    next_syncPd  = {syncPd[0], fullPowerDown};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncFmt <= dao_pkg::SYNC_LOW;
      syncOe  <= dao_pkg::SYNC_HIGH;
      syncPd  <= dao_pkg::SYNC_LOW;
    end else begin
      syncFmt <= next_syncFmt;
      syncOe  <= next_syncOe;
      syncPd  <= next_syncPd;
    end
  end

  assign fmtTwos  = syncFmt[1];
  assign oeActive = !syncOe[1];
  assign pdActive = syncPd[1];

  // Conversion pipeline. The nine half-cycle stages fold into whole-cycle
  // registers here, since only the word at the far end is observable.
  logic [dao_pkg::PAIR_W-1:0] pipeData [PIPE];
  logic [dao_pkg::PAIR_W-1:0] next_pipeData [PIPE];
  logic [PIPE-1:0]            pipeValid;
  logic [PIPE-1:0]            next_pipeValid;

  always_comb begin
    // Both channels enter on the same edge as one pair.
    next_pipeData[0]  = {correct(chanADecision), correct(chanBDecision)};
    next_pipeValid[0] = sampleValid && !pdActive;
    for (int k = 1; k < PIPE; k++) begin
      next_pipeData[k]  = pipeData[k-1];
      next_pipeValid[k] = pipeValid[k-1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < PIPE; k++) begin
        pipeData[k] <= '0;
      end
      pipeValid <= '0;
    end else begin
      pipeData  <= next_pipeData;
      pipeValid <= next_pipeValid;
    end
  end

  // The fifo rides out power-down: reads stop so the buses hold, and new samples are
  // dropped at the pipeline input; sampleReady falls only if the fifo fills, and nothing stalls.
  dao_stream_if #(.WIDTH(dao_pkg::PAIR_W)) fifoIn ();
  dao_stream_if #(.WIDTH(dao_pkg::PAIR_W)) fifoOut ();

  assign fifoIn.valid  = pipeValid[PIPE-1];
  assign fifoIn.data   = pipeData[PIPE-1];
  assign fifoOut.ready = !pdActive;
  assign sampleReady   = fifoIn.ready;

  dao_fifo #(
    .WIDTH (dao_pkg::PAIR_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrSide  (fifoIn),
    .rdSide  (fifoOut)
  );

  // Output latch, the last of the five cycles of latency.
  logic [dao_pkg::DATA_W-1:0] next_chanAData;
  logic [dao_pkg::DATA_W-1:0] next_chanBData;
  logic                       next_oe;
  logic                       oeReg;

  always_comb begin
    next_chanAData = chanAData;
    next_chanBData = chanBData;
    if (fifoOut.valid) begin
      next_chanAData = encode(fifoOut.data[dao_pkg::PAIR_W-1:dao_pkg::DATA_W], fmtTwos);
      next_chanBData = encode(fifoOut.data[dao_pkg::DATA_W-1:0], fmtTwos);
    end
    next_oe = oeActive;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chanAData <= dao_pkg::DATA_RESET;
      chanBData <= dao_pkg::DATA_RESET;
      oeReg     <= 1'b0;
    end else begin
      chanAData <= next_chanAData;
      chanBData <= next_chanBData;
      oeReg     <= next_oe;
    end
  end

  assign chanADataOe = oeReg;
  assign chanBDataOe = oeReg;
endmodule : dao_formatter

// ===== sim/dao_capture_model.sv
`timescale 1ns/100ps
module dao_capture_model (
  input  wire logic [9:0] chanAData,
  input  wire logic [9:0] chanBData,
  input  wire logic       chanADataOe,
  input  wire logic       chanBDataOe,
  input  wire logic       clk_sys,
  output logic      [9:0] busA,
  output logic      [9:0] busB,
  output logic      [9:0] capA,
  output logic      [9:0] capB
);
  logic [9:0] lastA = 10'h000;
  logic [9:0] lastB = 10'h000;
  // A released bus shows the inverse of its last level so stale data never looks valid.
  assign busA = chanADataOe ? chanAData : ~lastA;
  assign busB = chanBDataOe ? chanBData : ~lastB;
  always @(posedge clk_sys) begin
    if (chanADataOe) lastA <= chanAData;
    if (chanBDataOe) lastB <= chanBData;
    capA <= busA;
    capB <= busB;
  end
endmodule : dao_capture_model

// ===== sim/dao_formatter_asserts.sv
`timescale 1ns/100ps
module dao_formatter_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       sampleValid,
  input wire logic       fullPowerDown,
  input wire logic       outEnable_b,
  input wire logic       sampleReady,
  input wire logic [9:0] chanAData,
  input wire logic       chanADataOe,
  input wire logic [9:0] chanBData,
  input wire logic       chanBDataOe
);
  logic [5:0] idle;
  logic [5:0] quiet;
  logic       pdEver;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle <= 6'h00;
      quiet <= 6'h00;
      pdEver <= 1'b0;
    end else begin
      idle <= sampleValid ? 6'h00 : idle + {5'h00, idle != 6'h3f};
      quiet <= fullPowerDown ? 6'h00 : quiet + {5'h00, quiet != 6'h3f};
      pdEver <= pdEver | fullPowerDown;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_oe_shared: assert property (chanADataOe == chanBDataOe) else $error("enables differ");
  a_oe_drive: assert property (!outEnable_b [*5] |-> chanADataOe) else $error("bus not driven");
  a_oe_release: assert property (outEnable_b [*5] |-> !chanADataOe) else $error("bus not released");
  a_reset_quiet: assert property ($rose(rst_b) |-> !chanADataOe && chanAData == 10'h000) else $error("bad reset");
  a_pd_hold: assert property (fullPowerDown [*6] |-> $stable(chanAData) && $stable(chanBData))
    else $error("data moved in power-down");
  a_pd_drive: assert property ((fullPowerDown && !outEnable_b) [*5] |-> chanADataOe) else $error("held bus off");
  a_idle_hold: assert property (idle > 6'd23 && quiet > 6'd23 |-> $stable({chanAData, chanBData}))
    else $error("data moved without a sample");
  a_ready_free: assert property (!pdEver |-> sampleReady) else $error("stream stalled");
  c_accept: cover property (sampleValid && sampleReady);
  c_pd: cover property (fullPowerDown [*6]);
  c_release: cover property ($fell(chanADataOe));
endmodule : dao_formatter_asserts

// ===== sim/test_dao_formatter.sv
`timescale 1ns/100ps
module test_dao_formatter;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        sampleValid = 1'b0;
  logic [17:0] chanADecision = 18'h00000;
  logic [17:0] chanBDecision = 18'h00000;
  logic        formatTwos = 1'b0;
  logic        outEnable_b = 1'b0;
  logic        fullPowerDown = 1'b0;
  logic        sampleReady, chanADataOe, chanBDataOe;
  logic [9:0]  chanAData, chanBData, busA, busB, capA, capB;
  logic [19:0] expQ[$];
  logic [19:0] expW, last;
  integer      seed = 32'h44a1;
  integer      err_count = 0;
  integer      n_checks = 0;
  integer      cyc = 0;
  dao_formatter uut (.clk_sys, .rst_b, .sampleValid, .chanADecision, .chanBDecision, .formatTwos,
    .outEnable_b, .fullPowerDown, .sampleReady, .chanAData, .chanADataOe, .chanBData, .chanBDataOe);
  dao_capture_model host (.chanAData, .chanBData, .chanADataOe, .chanBDataOe, .clk_sys, .busA, .busB, .capA, .capB);
  initial forever #25 clk_sys = ~clk_sys;
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      wrap_up();
    end
  end
  task check(input string name, input logic [19:0] seen, input logic [19:0] want);
    n_checks = n_checks + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  function automatic logic [9:0] enc(input logic [17:0] d, input logic tw);
    integer s, v, sum;
    sum = d[1:0];
    for (s = 0; s < 8; s++) begin
      v = d[17-2*s -: 2];
      sum += (v == 3 ? 2 : v) << (8 - s);
    end
    enc = 10'(sum) ^ {tw, 9'h000};
  endfunction : enc
  // The first two channel A samples of a stream pin the bottom and top codes.
  function automatic logic [17:0] rdec(input integer i);
    integer s;
    rdec = (i == 1) ? 18'h3ffff : 18'h00000;
    for (s = 0; s < 9 && i > 1; s++) rdec[2*s +: 2] = 2'({$random(seed)} % (s == 0 ? 4 : 3));
  endfunction : rdec
  task stream(input integer n, input logic tw);
    integer i;
    for (i = 0; i < n + 6; i++) begin
      @(negedge clk_sys);
      if (i >= 7) check("capture", {capA, capB}, expW);
      if (i >= 6) begin
        expW = expQ.pop_front();
        check("data", {chanAData, chanBData}, expW);
      end
      sampleValid = i < n;
      chanADecision = rdec(i);
      chanBDecision = rdec(i + 2);
      if (i < n) expQ.push_back({enc(chanADecision, tw), enc(chanBDecision, tw)});
    end
  endtask : stream
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    stream(20, 1'b0);
    formatTwos = 1'b1;
    repeat (4) @(negedge clk_sys);
    stream(20, 1'b1);
    last = {chanAData, chanBData};
    outEnable_b = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("enable", {18'h00000, chanADataOe, chanBDataOe}, 20'h00000);
    outEnable_b = 1'b0;
    repeat (6) @(negedge clk_sys);
    check("enable", {18'h00000, chanADataOe, chanBDataOe}, 20'h00003);
    // One sample enters with power-down; it must wait in the fifo until wake-up.
    fullPowerDown = 1'b1;
    sampleValid = 1'b1;
    chanADecision = rdec(5);
    chanBDecision = rdec(6);
    expQ.push_back({enc(chanADecision, 1'b1), enc(chanBDecision, 1'b1)});
    @(negedge clk_sys);
    sampleValid = 1'b0;
    repeat (4) @(negedge clk_sys);
    chanADecision = rdec(7);
    sampleValid = 1'b1;
    repeat (10) @(negedge clk_sys);
    sampleValid = 1'b0;
    check("hold", {chanAData, chanBData}, last);
    check("enable", {18'h00000, chanADataOe, chanBDataOe}, 20'h00003);
    check("ready", {19'h00000, sampleReady}, 20'h00001);
    fullPowerDown = 1'b0;
    repeat (30) @(negedge clk_sys);
    check("wake", {chanAData, chanBData}, expQ.pop_front());
    wrap_up();
  end
endmodule : test_dao_formatter
bind dao_formatter dao_formatter_asserts chk (.clk_sys, .rst_b, .sampleValid, .fullPowerDown, .outEnable_b,
  .sampleReady, .chanAData, .chanADataOe, .chanBData, .chanBDataOe);
